// file: core/lwss_defs.vh
`ifndef LWSS_DEFS_VH
`define LWSS_DEFS_VH
`define LWSS_LANES 4
`define LWSS_LANE_W 9
`define LWSS_SEED_W 2
`define LWSS_ADDR_W 10
`define LWSS_CMD_IDLE 2'h0
`define LWSS_CMD_READ 2'h1
`define LWSS_CMD_WRITE 2'h2
`define LWSS_LANE_ALL_OFF 4'hF
`define LWSS_STEP_ZERO 2'h0
`define LWSS_ASYNC_N 3
`define LWSS_SYNC_W 3
`define LWSS_ASYNC_IDLE 3'h5
`endif

// file: core/lwss_sram.v
`include "lwss_defs.vh"
module lwss_sram #(
	parameter ADDR_W = `LWSS_ADDR_W,
	parameter LANE_W = `LWSS_LANE_W
) (
	input wire ref_clk,
	input wire rst,
	input wire clock_gate_n,
	input wire chip_select_a_n,
	input wire chip_select_b,
	input wire chip_select_c_n,
	input wire write_strobe_n,
	input wire lane0_write_n,
	input wire lane1_write_n,
	input wire lane2_write_n,
	input wire lane3_write_n,
	input wire burst_step_or_load,
	input wire [ADDR_W-1:0] address,
	input wire output_enable_n,
	input wire sleep_request,
	input wire pipeline_bypass_sel_n,
	input wire linear_order_sel_n,
	input wire [LANE_W-1:0] lane0_data_in,
	input wire [LANE_W-1:0] lane1_data_in,
	input wire [LANE_W-1:0] lane2_data_in,
	input wire [LANE_W-1:0] lane3_data_in,
	output reg [LANE_W-1:0] lane0_data_out,
	output reg [LANE_W-1:0] lane1_data_out,
	output reg [LANE_W-1:0] lane2_data_out,
	output reg [LANE_W-1:0] lane3_data_out,
	output reg data_oe,
	output reg sleeping
);
	localparam DEPTH = 1 << ADDR_W;
	localparam LANES = `LWSS_LANES;
	localparam SEED_W = `LWSS_SEED_W;
	localparam WORD_W = LANE_W * LANES;
	localparam ASYNC_N = `LWSS_ASYNC_N;
	localparam SYNC_W = `LWSS_SYNC_W;
	// Bit positions of the asynchronous inputs in the sync vector
	localparam SYN_OE = 0;
	localparam SYN_ZZ = 1;
	localparam SYN_LBO = 2;
	localparam [ASYNC_N-1:0] ASYNC_IDLE = `LWSS_ASYNC_IDLE;
	// Burst states: what a continue cycle repeats
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_READ = 2'h1;
	localparam [1:0] ST_WRITE = 2'h2;
	// Synchronised asynchronous inputs
	wire [ASYNC_N-1:0] async_in;
	wire [ASYNC_N-1:0] async_q;
	wire oe_n_q;
	wire zz_q;
	wire lbo_n_q;
	// Burst state
	reg [1:0] burst_state;
	reg [1:0] next_burst_state;
	reg [ADDR_W-1:0] base_addr;
	reg [SEED_W-1:0] seed;
	reg [SEED_W-1:0] step;
	// Command pipe: stage 1 after capture, stage 2 one edge later
	reg [1:0] next_cmd;
	reg [1:0] cmd1;
	reg [1:0] cmd2;
	reg [ADDR_W-1:0] addr1;
	reg [ADDR_W-1:0] addr2;
	reg [LANES-1:0] lanes1;
	reg [LANES-1:0] lanes2;
	reg drive;
	wire edge_ok;
	wire selected;
	wire [LANES-1:0] lane_n;
	wire flow;
	wire [SEED_W-1:0] next_step;
	wire [ADDR_W-1:0] burst_addr;
	wire [WORD_W-1:0] wr_word;
	wire [WORD_W-1:0] rd_word;
	wire [ADDR_W-1:0] next_addr;
	wire [ADDR_W-1:0] rd_addr;
	wire next_drive;
	wire [1:0] due_cmd;
	wire [ADDR_W-1:0] due_addr;
	wire [LANES-1:0] due_lanes;
	function [SEED_W-1:0] burst_low;
		input [SEED_W-1:0] s;
		input [SEED_W-1:0] k;
		input lin_n;
		begin
			if (lin_n)
				burst_low = s ^ k;
			else
				burst_low = s + k;
		end
	endfunction
	function is_read;
		input [1:0] c;
		begin
			is_read = (c == `LWSS_CMD_READ);
		end
	endfunction
	function is_write;
		input [1:0] c;
		begin
			is_write = (c == `LWSS_CMD_WRITE);
		end
	endfunction
	assign async_in = {linear_order_sel_n, sleep_request, output_enable_n};
	assign oe_n_q = async_q[SYN_OE];
	assign zz_q = async_q[SYN_ZZ];
	assign lbo_n_q = async_q[SYN_LBO];
	// Four flops each; a change counts once the 2nd and 3rd agree.
	// Costs a few cycles on oe and sleep, but keeps one clock domain.
	genvar a;
	generate
		for (a = 0; a < ASYNC_N; a = a + 1) begin : sync
			reg [SYNC_W-1:0] chain;
			reg level;
			always @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					chain <= {SYNC_W{ASYNC_IDLE[a]}};
					level <= ASYNC_IDLE[a];
				end else begin
					chain <= {chain[SYNC_W-2:0], async_in[a]};
					if (chain[1] == chain[2]) begin
						level <= chain[2];
					end
				end
			end
			assign async_q[a] = level;
		end
	endgenerate
	assign edge_ok = ~clock_gate_n & ~zz_q;
	assign selected = ~chip_select_a_n & chip_select_b
		& ~chip_select_c_n;
	assign lane_n = {lane3_write_n, lane2_write_n, lane1_write_n,
		lane0_write_n};
	assign flow = ~pipeline_bypass_sel_n;
	assign next_step = step + 1'b1;
	assign burst_addr = {base_addr[ADDR_W-1:SEED_W],
		burst_low(seed, next_step, lbo_n_q)};
	// Step/load low loads a fresh address and command
	always @* begin
		next_burst_state = burst_state;
		if (!burst_step_or_load) begin
			if (!selected) begin
				next_burst_state = ST_IDLE;
			end else if (write_strobe_n) begin
				next_burst_state = ST_READ;
			end else begin
				next_burst_state = ST_WRITE;
			end
		end
	end
	// A continue cycle keeps the state, so it repeats the loaded op
	always @* begin
		case (next_burst_state)
			ST_READ: begin
				next_cmd = `LWSS_CMD_READ;
			end
			ST_WRITE: begin
				next_cmd = `LWSS_CMD_WRITE;
			end
			default: begin
				next_cmd = `LWSS_CMD_IDLE;
			end
		endcase
	end
	assign next_addr = burst_step_or_load ? burst_addr : address;
	// Flow-through takes the op one stage early
	assign due_cmd = flow ? cmd1 : cmd2;
	assign due_addr = flow ? addr1 : addr2;
	assign due_lanes = flow ? lanes1 : lanes2;
	// Pipelined reads leave the output register one edge after capture
	assign rd_addr = flow ? next_addr : addr1;
	assign next_drive = flow ? is_read(next_cmd) : is_read(cmd1);
	assign wr_word = {lane3_data_in, lane2_data_in, lane1_data_in,
		lane0_data_in};
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			burst_state <= ST_IDLE;
			base_addr <= {ADDR_W{1'b0}};
			seed <= `LWSS_STEP_ZERO;
			step <= `LWSS_STEP_ZERO;
			cmd1 <= `LWSS_CMD_IDLE;
			cmd2 <= `LWSS_CMD_IDLE;
			addr1 <= {ADDR_W{1'b0}};
			addr2 <= {ADDR_W{1'b0}};
			lanes1 <= `LWSS_LANE_ALL_OFF;
			lanes2 <= `LWSS_LANE_ALL_OFF;
		end else if (edge_ok) begin
			burst_state <= next_burst_state;
			cmd1 <= next_cmd;
			addr1 <= next_addr;
			lanes1 <= lane_n;
			cmd2 <= cmd1;
			addr2 <= addr1;
			lanes2 <= lanes1;
			if (!burst_step_or_load) begin
				base_addr <= address;
				seed <= address[SEED_W-1:0];
				step <= `LWSS_STEP_ZERO;
			end else begin
				step <= next_step;
			end
		end
	end
	// One store per lane, so each lane is written or kept whole
	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1) begin : lane
			reg [LANE_W-1:0] store [0:DEPTH-1];
			wire wen;
			wire hit;
			wire [LANE_W-1:0] din;
			// An abort has all lanes off, so nothing is written
			assign wen = edge_ok & is_write(due_cmd)
				& ~due_lanes[g];
			assign din = wr_word[g*LANE_W +: LANE_W];
			assign hit = wen && (due_addr == rd_addr);
			always @(posedge ref_clk) begin
				if (wen) begin
					store[due_addr] <= din;
				end
			end
			// Forward a write landing on this edge to a read behind it
			assign rd_word[g*LANE_W +: LANE_W] = hit ? din :
				store[rd_addr];
		end
	endgenerate
	// Data and enable are loaded on the same edge so they stay aligned
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lane0_data_out <= {LANE_W{1'b0}};
			lane1_data_out <= {LANE_W{1'b0}};
			lane2_data_out <= {LANE_W{1'b0}};
			lane3_data_out <= {LANE_W{1'b0}};
			drive <= 1'b0;
			data_oe <= 1'b0;
			sleeping <= 1'b0;
		end else begin
			sleeping <= zz_q;
			if (edge_ok) begin
				lane0_data_out <= rd_word[0*LANE_W +: LANE_W];
				lane1_data_out <= rd_word[1*LANE_W +: LANE_W];
				lane2_data_out <= rd_word[2*LANE_W +: LANE_W];
				lane3_data_out <= rd_word[3*LANE_W +: LANE_W];
				drive <= next_drive;
				data_oe <= next_drive & ~oe_n_q;
			end else begin
				// A stalled read keeps driving; sleep turns it off
				if (zz_q) begin
					drive <= 1'b0;
				end
				data_oe <= drive & ~oe_n_q & ~zz_q;
			end
		end
	end
endmodule

// file: dv/lwss_ctl_model.sv
module lwss_ctl_model (
	input wire logic ref_clk,
	input wire logic clock_gate_n,
	input wire logic pipe,
	input wire logic wr,
	input wire logic [35:0] wd,
	output logic [35:0] dq
);
	timeunit 1ns;
	timeprecision 100ps;
	logic v1 = 0, v2 = 0;
	logic [35:0] w1 = 0, w2 = 0;
	always @(posedge ref_clk) if (!clock_gate_n) begin
		{v2, v1} <= {v1, wr};
		{w2, w1} <= {w1, wd};
	end
	// Outside its slot the bus shows inverted data, so a stale value fails
	assign dq = pipe ? (v2 ? w2 : ~w2) : (v1 ? w1 : ~w1);
endmodule

// file: dv/lwss_sram_monitor.sv
module lwss_sram_monitor (
	input wire ref_clk,
	input wire rst,
	input wire clock_gate_n,
	input wire chip_select_a_n,
	input wire chip_select_b,
	input wire chip_select_c_n,
	input wire write_strobe_n,
	input wire burst_step_or_load,
	input wire output_enable_n,
	input wire sleep_request,
	input wire pipeline_bypass_sel_n,
	input wire data_oe,
	input wire sleeping
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	wire go = !clock_gate_n && !sleeping && !output_enable_n
		&& !burst_step_or_load;
	wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
	wire rd = go && sel && write_strobe_n;
	wire wr = go && sel && !write_strobe_n;
	wire pipe = pipeline_bypass_sel_n;
	a_gate_hold: assert property (clock_gate_n |=> $stable(data_oe))
		else $error("gated edge moved data_oe");
	a_pipe_read: assert property (rd && pipe ##1 !clock_gate_n
		|-> ##1 data_oe) else $error("pipelined read data late");
	a_flow_read: assert property (rd && !pipe |-> ##1 data_oe)
		else $error("flow read data late");
	a_write_off: assert property (wr && pipe |-> ##2 !data_oe)
		else $error("drivers on in write slot");
	a_desel_off: assert property (go && !sel && pipe |-> ##2 !data_oe)
		else $error("drivers on after deselect");
	a_turn_flow: assert property (rd && !pipe ##1 wr |->
		data_oe ##1 !data_oe) else $error("read write turn wrong");
	a_sleep_entry: assert property (sleep_request [*6] |-> sleeping)
		else $error("sleep not entered");
	a_sleep_quiet: assert property (sleeping [*2] |-> !data_oe)
		else $error("drivers on while asleep");
	c_pipe_read: cover property (rd && pipe);
	c_turn: cover property (rd && !pipe ##1 wr);
	c_sleep: cover property (sleeping);
endmodule
bind lwss_sram lwss_sram_monitor i_lwss_sram_monitor (.*);

// file: dv/lwss_sram_tb.sv
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	bad_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module lwss_sram_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [35:0] W = 36'h1_2345_6789;
	localparam logic [2:0] SEL = 3'b010;
	logic ref_clk = 0, rst = 1, clock_gate_n = 0, output_enable_n = 0;
	logic chip_select_a_n = 1, chip_select_b = 0, chip_select_c_n = 1;
	logic write_strobe_n = 1, burst_step_or_load = 0, sleep_request = 0;
	logic pipeline_bypass_sel_n = 1, linear_order_sel_n = 0, wr = 0;
	logic lane0_write_n = 1, lane1_write_n = 1, lane2_write_n = 1;
	logic lane3_write_n = 1, data_oe, sleeping;
	logic [9:0] address = 0, base;
	logic [1:0] s;
	logic [35:0] wd = 0, dq;
	logic [8:0] lane0_data_out, lane1_data_out, lane2_data_out;
	logic [8:0] lane3_data_out;
	wire [8:0] lane0_data_in = dq[8:0];
	wire [8:0] lane1_data_in = dq[17:9];
	wire [8:0] lane2_data_in = dq[26:18];
	wire [8:0] lane3_data_in = dq[35:27];
	int bad_count = 0, samples_checked = 0;
	always #12.5 ref_clk = ~ref_clk;
	lwss_ctl_model i_lwss_ctl_model (.ref_clk(ref_clk), .clock_gate_n(clock_gate_n),
		.pipe(pipeline_bypass_sel_n), .wr(wr), .wd(wd), .dq(dq));
	lwss_sram i_lwss_sram (
		.ref_clk(ref_clk),
		.rst(rst),
		.clock_gate_n(clock_gate_n),
		.chip_select_a_n(chip_select_a_n),
		.chip_select_b(chip_select_b),
		.chip_select_c_n(chip_select_c_n),
		.write_strobe_n(write_strobe_n),
		.lane0_write_n(lane0_write_n),
		.lane1_write_n(lane1_write_n),
		.lane2_write_n(lane2_write_n),
		.lane3_write_n(lane3_write_n),
		.burst_step_or_load(burst_step_or_load),
		.address(address),
		.output_enable_n(output_enable_n),
		.sleep_request(sleep_request),
		.pipeline_bypass_sel_n(pipeline_bypass_sel_n),
		.linear_order_sel_n(linear_order_sel_n),
		.lane0_data_in(lane0_data_in),
		.lane1_data_in(lane1_data_in),
		.lane2_data_in(lane2_data_in),
		.lane3_data_in(lane3_data_in),
		.lane0_data_out(lane0_data_out),
		.lane1_data_out(lane1_data_out),
		.lane2_data_out(lane2_data_out),
		.lane3_data_out(lane3_data_out),
		.data_oe(data_oe),
		.sleeping(sleeping)
	);
	task automatic op(input logic [2:0] cs, input logic w, input logic [3:0] m,
		input logic [9:0] a, input logic t, input logic [35:0] d);
		@(posedge ref_clk);
		{chip_select_a_n, chip_select_b, chip_select_c_n} <= cs;
		{lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n} <= m;
		{write_strobe_n, address, burst_step_or_load} <= {!w, a, t};
		{wr, wd} <= {w, d};
	endtask
	task automatic idle(input int n);
		@(posedge ref_clk);
		{chip_select_a_n, burst_step_or_load, wr} <= 3'b100;
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic rdchk(input logic [9:0] a, input logic [35:0] e);
		op(SEL, 0, 4'hF, a, 0, 0);
		idle(pipeline_bypass_sel_n ? 1 : 0);
		#1;
		`CHK("read word", e, {lane3_data_out, lane2_data_out,
			lane1_data_out, lane0_data_out})
		`CHK("read enable", 1'b1, data_oe)
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 0;
		idle(6);
		for (int p = 0; p < 2; p++) begin
			pipeline_bypass_sel_n <= p[0];
			for (int o = 0; o < 2; o++) begin
				linear_order_sel_n <= o[0];
				base = 10'(8 * p + 4 * o + 64);
				s = 2'(2 - o);
				idle(6);
				// Five accesses: the fifth wraps onto the seed address
				for (int k = 0; k < 5; k++)
					op(SEL, 1, 0, base + s, k > 0, 36'(k * 99 + base));
				for (int k = 0; k < 4; k++)
					rdchk(base + 2'(o ? s ^ 2'(k) : s + 2'(k)),
						36'((k ? k : 4) * 99 + base));
			end
			op(SEL, 1, 0, 5, 0, W);
			op(SEL, 0, 4'hF, 5, 0, 0);
			op(SEL, 1, 4'hA, 5, 0, '1);
			op(SEL, 1, 4'hF, 5, 0, 0);
			for (int i = 0; i < 3; i++)
				op(SEL ^ (3'b100 >> i), 1, 0, 5, 0, 0);
			op(SEL, 1, 0, 5, 0, 0);
			clock_gate_n <= 1;
			idle(2);
			clock_gate_n <= 0;
			rdchk(5, {W[35:27], 9'h1FF, W[17:9], 9'h1FF});
		end
		sleep_request <= 1;
		idle(8);
		`CHK("asleep", 2'b10, {sleeping, data_oe})
		sleep_request <= 0;
		idle(8);
		report_and_stop();
	end
endmodule
